// >>> hdl/psc_sideband_regs.sv
// psc_sideband_regs.sv: processor sideband control register bank, reached
// over byte-wide i/o cycles from the processor.
// assumes io strobes are one-cycle pulses on MCLK, and ALT_ACCESS and
// FPU_ERR_IRQ_EN come from configuration logic on the same clock.
`include "psc_params.svh"
`default_nettype none

module psc_sideband_regs #(
	parameter logic [31:0] BUSRST_CYCLES = `PSC_BUSRST_CYCLES,
	parameter logic [31:0] SLEEP_CYCLES  = `PSC_SLEEP_CYCLES
) (
	// clock and reset
	input  wire logic        MCLK,
	input  wire logic        RST_N,
	// processor i/o cycles
	input  wire logic [15:0] IO_ADDR,
	input  wire logic        IO_WR,
	input  wire logic        IO_RD,
	input  wire logic [7:0]  IO_WDATA,
	output logic      [7:0]  IO_RDATA,
	output logic             IO_RDATA_VALID,
	// configuration from the rest of the device
	input  wire logic        ALT_ACCESS,
	input  wire logic        FPU_ERR_IRQ_EN,
	// pins from the board
	input  wire logic        ADDR20_GATE_IN,
	input  wire logic        FLOAT_ERROR_IN_N,
	input  wire logic        POWER_GOOD_IN,
	input  wire logic        RESUME_WELL_RESET_IN_N,
	input  wire logic        WATCHDOG_TIMEOUT_IN,
	// processor and clock block outputs
	output logic             NMI_MASK,
	output logic      [6:0]  CLOCK_REG_SELECT,
	output logic             ADDR20_MASK_OUT_N,
	output logic             INIT_N,
	output logic             FPU_INTERRUPT,
	output logic             IGNORE_NUMERIC_ERROR_N,
	// reset and power outputs
	output logic             BUS_RESET_N,
	output logic             RESUME_BITS_CLEAR,
	output logic             SLEEP_STATE3_OUT_N,
	output logic             SLEEP_STATE4_OUT_N,
	output logic             SLEEP_STATE5_OUT_N
);

	// ============================================================
	// inputs
	psc_pkg::psc_io_req_t req;
	psc_pkg::psc_pins_t   pins;
	logic [4:0]           pins_raw;
	logic [4:0]           pins_q;

	assign req.addr  = IO_ADDR;
	assign req.wr    = IO_WR;
	assign req.rd    = IO_RD;
	assign req.wdata = IO_WDATA;
	assign pins_raw  = {WATCHDOG_TIMEOUT_IN, RESUME_WELL_RESET_IN_N, POWER_GOOD_IN,
	                    FLOAT_ERROR_IN_N, ADDR20_GATE_IN};
	assign pins      = psc_pkg::psc_pins_t'(pins_q);

	psc_pin_sync #(
		.W       (5),
		.RST_VAL (`PSC_PINS_RST)
	) u_sync (
		.clk   (MCLK),
		.rst_n (RST_N),
		.d     (pins_raw),
		.q     (pins_q)
	);

	function automatic logic hit(input psc_pkg::psc_io_req_t r, input logic [15:0] a);
		hit = (r.addr == a);
	endfunction

	logic wr_nmi;
	logic wr_fast;
	logic wr_nerr;
	logic wr_rstc;

	assign wr_nmi  = req.wr && (hit(req, `PSC_IO_NMI_INDEX) || hit(req, `PSC_IO_NMI_ALIAS));
	assign wr_fast = req.wr && hit(req, `PSC_IO_FAST_GATE);
	assign wr_nerr = req.wr && hit(req, `PSC_IO_NUM_ERR);
	assign wr_rstc = req.wr && hit(req, `PSC_IO_RST_CTRL);

	// ============================================================
	// register file and triggers
	logic [7:0] nmi_idx_r;
	logic [7:0] nmi_idx_nxt;
	logic       alt_gate_r;
	logic       alt_gate_nxt;
	logic       cpu_init_trigger_r;
	logic       cpu_init_trigger_nxt;
	logic       full_rst_r;
	logic       full_rst_nxt;
	logic       rst_cpu_r;
	logic       rst_cpu_nxt;
	logic       hard_sel_r;
	logic       hard_sel_nxt;
	logic       init_act;
	logic       init_act_prev_r;
	logic       init_rise;
	logic       rst_start;
	logic       soft_start;
	logic       hard_start;
	logic       init_start;

	assign init_rise  = init_act && !init_act_prev_r;
	assign rst_start  = wr_rstc && req.wdata[`PSC_RST_CPU_BIT] && !rst_cpu_r;
	assign soft_start = rst_start && !req.wdata[`PSC_HARD_SEL_BIT];
	assign hard_start = rst_start && req.wdata[`PSC_HARD_SEL_BIT];
	assign init_start = (wr_fast && req.wdata[`PSC_INIT_TRIG_BIT] && !cpu_init_trigger_r)
	                    || soft_start;

	always_comb begin
		nmi_idx_nxt  = wr_nmi ? req.wdata : nmi_idx_r;
		alt_gate_nxt = wr_fast ? req.wdata[`PSC_ALT_GATE_BIT] : alt_gate_r;
		if (init_rise)
			alt_gate_nxt = 1'b1;
		cpu_init_trigger_nxt = wr_fast ? req.wdata[`PSC_INIT_TRIG_BIT] : cpu_init_trigger_r;
		full_rst_nxt = wr_rstc ? req.wdata[`PSC_FULL_RST_BIT] : full_rst_r;
		rst_cpu_nxt  = wr_rstc ? req.wdata[`PSC_RST_CPU_BIT] : rst_cpu_r;
		hard_sel_nxt = wr_rstc ? req.wdata[`PSC_HARD_SEL_BIT] : hard_sel_r;
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			nmi_idx_r       <= `PSC_NMI_RST;
			alt_gate_r      <= 1'(`PSC_FAST_RST >> `PSC_ALT_GATE_BIT);
			cpu_init_trigger_r      <= 1'b0;
			full_rst_r      <= 1'b0;
			rst_cpu_r       <= 1'b0;
			hard_sel_r      <= 1'b0;
			init_act_prev_r <= 1'b0;
		end else begin
			nmi_idx_r       <= nmi_idx_nxt;
			alt_gate_r      <= alt_gate_nxt;
			cpu_init_trigger_r      <= cpu_init_trigger_nxt;
			full_rst_r      <= full_rst_nxt;
			rst_cpu_r       <= rst_cpu_nxt;
			hard_sel_r      <= hard_sel_nxt;
			init_act_prev_r <= init_act;
		end
	end

	// ============================================================
	// read path
	logic [7:0] rdata_nxt;

	always_comb begin
		unique case (req.addr)
			`PSC_IO_NMI_INDEX: rdata_nxt = {nmi_idx_r[7], ALT_ACCESS ? nmi_idx_r[6:0] : 7'h00};
			`PSC_IO_NMI_ALIAS: rdata_nxt = nmi_idx_r;
			`PSC_IO_FAST_GATE: rdata_nxt = {6'h00, alt_gate_r, cpu_init_trigger_r};
			`PSC_IO_NUM_ERR:   rdata_nxt = 8'h00;
			`PSC_IO_RST_CTRL:  rdata_nxt = {4'h0, full_rst_r, rst_cpu_r, hard_sel_r, 1'b0};
			default:           rdata_nxt = `PSC_UNMAPPED_RD;
		endcase
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			IO_RDATA       <= 8'h00;
			IO_RDATA_VALID <= 1'b0;
		end else begin
			IO_RDATA       <= req.rd ? rdata_nxt : IO_RDATA;
			IO_RDATA_VALID <= req.rd;
		end
	end

	// ============================================================
	// numeric error handling
	logic float_error_in_act;
	logic fpu_irq_nxt;
	logic ignore_numeric_error_out_nxt;

	assign float_error_in_act = !pins.float_err_n;

	always_comb begin
		fpu_irq_nxt = float_error_in_act && (FPU_ERR_IRQ_EN || FPU_INTERRUPT);
		ignore_numeric_error_out_nxt   = !IGNORE_NUMERIC_ERROR_N && float_error_in_act;
		if (wr_nerr && FPU_INTERRUPT)
			ignore_numeric_error_out_nxt = 1'b1;
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			FPU_INTERRUPT          <= 1'b0;
			IGNORE_NUMERIC_ERROR_N <= 1'b1;
		end else begin
			FPU_INTERRUPT          <= fpu_irq_nxt;
			IGNORE_NUMERIC_ERROR_N <= !ignore_numeric_error_out_nxt;
		end
	end

	// ============================================================
	// pulse timers
	logic busrst_act;
	logic sleep_act;
	logic sleep_event;

	psc_pulse_timer #(
		.W      (5),
		.CYCLES (5'(`PSC_INIT_CLKS))
	) u_init_tmr (
		.clk    (MCLK),
		.rst_n  (RST_N),
		.start  (init_start),
		.active (init_act)
	);

	psc_pulse_timer #(
		.W      (32),
		.CYCLES (BUSRST_CYCLES)
	) u_busrst_tmr (
		.clk    (MCLK),
		.rst_n  (RST_N),
		.start  (hard_start),
		.active (busrst_act)
	);

	psc_pulse_timer #(
		.W      (32),
		.CYCLES (SLEEP_CYCLES)
	) u_sleep_tmr (
		.clk    (MCLK),
		.rst_n  (RST_N),
		.start  (sleep_event && full_rst_r),
		.active (sleep_act)
	);

	// ============================================================
	// power events
	logic       pg_prev_r;
	logic       wdt_prev_r;
	logic [1:0] wdt_cnt_r;
	logic [1:0] wdt_cnt_nxt;
	logic       wdt_rise;
	logic       pg_fall;

	assign wdt_rise    = pins.wdt_timeout && !wdt_prev_r;
	assign pg_fall     = pg_prev_r && !pins.power_good && pins.resume_rst_n;
	assign sleep_event = hard_start || pg_fall || (wdt_rise && (wdt_cnt_nxt == `PSC_WDT_LIMIT));

	always_comb begin
		wdt_cnt_nxt = wdt_rise ? wdt_cnt_r + 2'h1 : wdt_cnt_r;
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			pg_prev_r  <= 1'b0;
			wdt_prev_r <= 1'b0;
			wdt_cnt_r  <= 2'h0;
		end else begin
			pg_prev_r  <= pins.power_good;
			wdt_prev_r <= pins.wdt_timeout;
			wdt_cnt_r  <= (wdt_cnt_nxt == `PSC_WDT_LIMIT) ? 2'h0 : wdt_cnt_nxt;
		end
	end

	// ============================================================
	// output flops
	logic addr20_mask_out_n_nxt;

	always_comb begin
		addr20_mask_out_n_nxt = alt_gate_r || pins.addr20_gate;
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			ADDR20_MASK_OUT_N  <= 1'b0;
			INIT_N             <= 1'b1;
			BUS_RESET_N        <= 1'b1;
			RESUME_BITS_CLEAR  <= 1'b0;
			SLEEP_STATE3_OUT_N <= 1'b1;
			SLEEP_STATE4_OUT_N <= 1'b1;
			SLEEP_STATE5_OUT_N <= 1'b1;
		end else begin
			ADDR20_MASK_OUT_N  <= addr20_mask_out_n_nxt;
			INIT_N             <= !init_act;
			BUS_RESET_N        <= !busrst_act;
			RESUME_BITS_CLEAR  <= hard_start;
			SLEEP_STATE3_OUT_N <= !sleep_act;
			SLEEP_STATE4_OUT_N <= !sleep_act;
			SLEEP_STATE5_OUT_N <= !sleep_act;
		end
	end

	assign NMI_MASK         = nmi_idx_r[`PSC_NMI_MASK_BIT];
	assign CLOCK_REG_SELECT = nmi_idx_r[6:0];

	// ============================================================
	// checks
	logic [4:0] init_low_cnt_r;

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N)
			init_low_cnt_r <= 5'h00;
		else
			init_low_cnt_r <= !INIT_N ? ((init_low_cnt_r == 5'h1f) ? 5'h1f : init_low_cnt_r + 5'h01) : 5'h00;
	end

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_N);

	nmi_mask_a: assert property (wr_nmi |=> NMI_MASK == $past(req.wdata[7]))
		else $error("nmi mask does not follow write");
	clock_index_a: assert property (wr_nmi |=> CLOCK_REG_SELECT == $past(req.wdata[6:0]))
		else $error("clock register select does not follow write");
	index_hidden_a: assert property (req.rd && hit(req, `PSC_IO_NMI_INDEX) && !ALT_ACCESS |=>
		IO_RDATA_VALID && IO_RDATA[6:0] == 7'h00)
		else $error("index visible at primary port outside alt access");
	alias_read_a: assert property (req.rd && hit(req, `PSC_IO_NMI_ALIAS) |=>
		IO_RDATA == {NMI_MASK, CLOCK_REG_SELECT})
		else $error("alias read does not return full register");
	addr20_or_a: assert property (1'b1 |=> ADDR20_MASK_OUT_N == $past(alt_gate_r | pins.addr20_gate))
		else $error("addr20 mask is not the or of gates");
	alt_set_a: assert property (init_rise |=> alt_gate_r)
		else $error("alternate gate not set by init");
	init_start_a: assert property (wr_fast && req.wdata[0] && !cpu_init_trigger_r |-> ##2 !INIT_N)
		else $error("init trigger did not start init pulse");
	init_width_a: assert property ($rose(INIT_N) |-> init_low_cnt_r >= 5'h10)
		else $error("init pulse shorter than 16 clocks");
	ignore_numeric_error_out_cause_a: assert property ($fell(IGNORE_NUMERIC_ERROR_N) |-> $past(wr_nerr && FPU_INTERRUPT))
		else $error("ignore_numeric_error_out asserted without write and interrupt");
	irq_enable_a: assert property ($rose(FPU_INTERRUPT) |-> $past(FPU_ERR_IRQ_EN && float_error_in_act))
		else $error("fpu interrupt raised while disabled");
	soft_reset_a: assert property (soft_start |-> ##2 (!INIT_N && BUS_RESET_N))
		else $error("soft reset did not drive init only");
	hard_reset_a: assert property (hard_start |-> ##1 RESUME_BITS_CLEAR ##1 (!BUS_RESET_N && INIT_N))
		else $error("hard reset sequence wrong");
	full_sleep_a: assert property (sleep_event && full_rst_r |-> ##2 (!SLEEP_STATE3_OUT_N
		&& !SLEEP_STATE4_OUT_N && !SLEEP_STATE5_OUT_N))
		else $error("full reset did not drive sleep outputs low");
	rewrite_a: assert property (wr_fast && req.wdata[0] && cpu_init_trigger_r && INIT_N && !init_act
		&& !soft_start |-> ##2 INIT_N)
		else $error("rewriting init trigger restarted init");

endmodule

`default_nettype wire

// >>> hdl/psc_params.svh
// psc_params.svh: offsets, field positions, reset values and timing counts
// for the processor sideband control registers.
// assumes a single 125 MHz block clock that also paces the processor pulses.
`ifndef PSC_PARAMS_SVH
`define PSC_PARAMS_SVH

// ============================================================
// i/o addresses
`define PSC_IO_NMI_INDEX   16'h0070
`define PSC_IO_NMI_ALIAS   16'h0074
`define PSC_IO_FAST_GATE   16'h0092
`define PSC_IO_NUM_ERR     16'h00f0
`define PSC_IO_RST_CTRL    16'h0cf9

// ============================================================
// field positions
`define PSC_NMI_MASK_BIT   7
`define PSC_ALT_GATE_BIT   1
`define PSC_INIT_TRIG_BIT  0
`define PSC_FULL_RST_BIT   3
`define PSC_RST_CPU_BIT    2
`define PSC_HARD_SEL_BIT   1

// ============================================================
// reset and read values
`define PSC_NMI_RST        8'h80
`define PSC_FAST_RST       8'h00
`define PSC_RSTC_RST       8'h00
`define PSC_UNMAPPED_RD    8'hff
`define PSC_PINS_RST       5'h02

// ============================================================
// timing
`define PSC_CLK_HZ         125000000
`define PSC_INIT_CLKS      16
`define PSC_BUSRST_TIME_US 1000
`define PSC_BUSRST_CYCLES  (`PSC_BUSRST_TIME_US * (`PSC_CLK_HZ / 1000000))
`define PSC_SLEEP_TIME_S   3
`define PSC_SLEEP_CYCLES   (`PSC_SLEEP_TIME_S * `PSC_CLK_HZ)
`define PSC_WDT_LIMIT      2'h2

`endif

// >>> hdl/psc_pkg.sv
// psc_pkg.sv: types shared by the sideband control register bank.
// assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package psc_pkg;

	// ============================================================
	// one i/o cycle from the processor
	typedef struct packed {
		logic [15:0] addr;
		logic        wr;
		logic        rd;
		logic [7:0]  wdata;
	} psc_io_req_t;

	// ============================================================
	// synchronised pin inputs, bit 4 first
	typedef struct packed {
		logic wdt_timeout;
		logic resume_rst_n;
		logic power_good;
		logic float_err_n;
		logic addr20_gate;
	} psc_pins_t;

endpackage

`default_nettype wire

// >>> hdl/psc_pin_sync.sv
// psc_pin_sync.sv: three-stage synchroniser for asynchronous pins.
// assumes the output is only trusted once stages two and three agree.
`default_nettype none

module psc_pin_sync #(
	parameter int            W       = 1,
	parameter logic [W-1:0]  RST_VAL = '0
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// pins and filtered result
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	logic [W-1:0] q_nxt;

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_comb begin
				q_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : q[i];
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_r <= RST_VAL;
			s2_r <= RST_VAL;
			s3_r <= RST_VAL;
			q    <= RST_VAL;
		end else begin
			s1_r <= d;
			s2_r <= s1_r;
			s3_r <= s2_r;
			q    <= q_nxt;
		end
	end

endmodule

`default_nettype wire

// >>> hdl/psc_pulse_timer.sv
// psc_pulse_timer.sv: loadable down counter giving a pulse of CYCLES clocks.
// assumes start is a one-cycle strobe; a start while busy restarts the count.
`default_nettype none

module psc_pulse_timer #(
	parameter int           W      = 32,
	parameter logic [W-1:0] CYCLES = 16
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// control
	input  wire logic start,
	output logic      active
);

	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;
	logic         active_nxt;

	always_comb begin
		if (start)
			cnt_nxt = CYCLES;
		else if (cnt_r != '0)
			cnt_nxt = cnt_r - 1'b1;
		else
			cnt_nxt = '0;
		active_nxt = (cnt_nxt != '0);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r  <= '0;
			active <= 1'b0;
		end else begin
			cnt_r  <= cnt_nxt;
			active <= active_nxt;
		end
	end

endmodule

`default_nettype wire

// >>> tb/psc_host_model.sv
// psc_host_model.sv: host processor i/o cycles and board sideband pins.
// assumes the bank answers a read within four clocks of the strobe.
`default_nettype none

module psc_host_model (
	// clock
	input  wire logic               clk,
	// i/o cycles
	output logic        [15:0]      io_addr,
	output logic                    io_wr,
	output logic                    io_rd,
	output logic        [7:0]       io_wdata,
	input  wire logic   [7:0]       io_rdata,
	input  wire logic               io_rdata_valid,
	// board pins
	output var psc_pkg::psc_pins_t  pins
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		io_addr  = 16'h0000;
		io_wr    = 1'b0;
		io_rd    = 1'b0;
		io_wdata = 8'h00;
		pins     = 5'h0e;
	end

	// ============================================================
	// one strobe; released bus shows the inverse, never the old value
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk);
		io_addr  = a;
		io_wdata = d;
		io_wr    = 1'b1;
		@(negedge clk);
		io_wr    = 1'b0;
		io_addr  = ~a;
		io_wdata = ~d;
	endtask

	task automatic rd(input logic [15:0] a, output logic [7:0] d, output bit ok);
		@(negedge clk);
		io_addr = a;
		io_rd   = 1'b1;
		@(negedge clk);
		io_rd   = 1'b0;
		io_addr = ~a;
		ok      = 1'b0;
		d       = 8'h00;
		for (int i = 0; i < 4 && !ok; i++) begin
			if (io_rdata_valid === 1'b1) begin
				d  = io_rdata;
				ok = 1'b1;
			end else
				@(negedge clk);
		end
	endtask

	task automatic set_pins(input psc_pkg::psc_pins_t p);
		@(negedge clk);
		pins = p;
	endtask
endmodule

`default_nettype wire

// >>> tb/tb.sv
// tb.sv: self-checking bench for the sideband control register bank.
// assumes shortened bus reset (20) and sleep (30) counts.
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic mclk = 1'b0, rst_n = 1'b0, alt = 1'b0, irq_en = 1'b0;
	logic [15:0] addr;
	logic wr_s, rd_s, vld, nmi, a20_n, init_n, fpu, ign_n, bus_n, clr, s3_n, s4_n, s5_n;
	logic [7:0] wdata, rdata;
	logic [6:0] sel;
	psc_pkg::psc_pins_t pins, p;
	int n_errors = 0;
	int compares = 0;
	int cyc = 0;
	int lo[6] = '{default: 0};
	int base[6] = '{default: 0};
	logic [7:0] m70 = 8'h80, m92 = 8'h00, mcf9 = 8'h00, d;
	localparam logic [15:0] ADDRS[7] = '{16'h0070, 16'h0074, 16'h0092, 16'h00f0, 16'h0cf9, 16'h0071, 16'h0cf8};

	psc_sideband_regs #(.BUSRST_CYCLES(32'd20), .SLEEP_CYCLES(32'd30)) psc_sideband_regs_inst (
		.MCLK(mclk), .RST_N(rst_n), .IO_ADDR(addr), .IO_WR(wr_s), .IO_RD(rd_s), .IO_WDATA(wdata),
		.IO_RDATA(rdata), .IO_RDATA_VALID(vld), .ALT_ACCESS(alt), .FPU_ERR_IRQ_EN(irq_en),
		.ADDR20_GATE_IN(pins.addr20_gate), .FLOAT_ERROR_IN_N(pins.float_err_n),
		.POWER_GOOD_IN(pins.power_good), .RESUME_WELL_RESET_IN_N(pins.resume_rst_n),
		.WATCHDOG_TIMEOUT_IN(pins.wdt_timeout), .NMI_MASK(nmi), .CLOCK_REG_SELECT(sel),
		.ADDR20_MASK_OUT_N(a20_n), .INIT_N(init_n), .FPU_INTERRUPT(fpu), .IGNORE_NUMERIC_ERROR_N(ign_n),
		.BUS_RESET_N(bus_n), .RESUME_BITS_CLEAR(clr), .SLEEP_STATE3_OUT_N(s3_n),
		.SLEEP_STATE4_OUT_N(s4_n), .SLEEP_STATE5_OUT_N(s5_n));

	psc_host_model psc_host_model_inst (.clk(mclk), .io_addr(addr), .io_wr(wr_s), .io_rd(rd_s),
		.io_wdata(wdata), .io_rdata(rdata), .io_rdata_valid(vld), .pins(pins));

	always #4 mclk = ~mclk;

	// ============================================================
	// active cycles of each pulse output, counted at falling edges
	always @(negedge mclk) begin
		lo[0] += (init_n === 1'b0);
		lo[1] += (bus_n === 1'b0);
		lo[2] += (s3_n === 1'b0);
		lo[3] += (s4_n === 1'b0);
		lo[4] += (s5_n === 1'b0);
		lo[5] += (clr === 1'b1);
	end

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 6000) begin
			n_errors++;
			$display("[FAIL] %0t run too long", $time);
			results();
		end
	end

	task automatic results();
		$display("compares %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ============================================================
	// compare tasks
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic chk_lvl(input logic got, input logic exp, input string what);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
		end
	endtask

	task automatic chk_cnt(input int got, input int exp, input string what);
		compares++;
		if (got != exp) begin
			n_errors++;
			$display("[FAIL] %0t %s got %0d exp %0d", $time, what, got, exp);
		end
	endtask

	// ============================================================
	// reference model of the register bank
	function automatic logic [7:0] exp_rd(input logic [15:0] a);
		case (a)
			16'h0070: return alt ? m70 : (m70 & 8'h80);
			16'h0074: return m70;
			16'h0092: return m92;
			16'h0cf9: return mcf9;
			16'h00f0: return 8'h00;
			default: return 8'hff;
		endcase
	endfunction

	task automatic io_write(input logic [15:0] a, input logic [7:0] dw);
		logic [7:0] v;
		v = (a == 16'h0092) ? (dw & 8'h03) : (a == 16'h0cf9) ? (dw & 8'h0e) : dw;
		if (a == 16'h0070 || a == 16'h0074)
			m70 = v;
		if (a == 16'h0092)
			m92 = v | ((v[0] & ~m92[0]) ? 8'h02 : 8'h00);
		if (a == 16'h0cf9) begin
			if (v[2] && !mcf9[2] && !v[1])
				m92[1] = 1'b1;
			mcf9 = v;
		end
		psc_host_model_inst.wr(a, v);
	endtask

	task automatic io_read(input logic [15:0] a);
		logic [7:0] dr;
		bit ok;
		psc_host_model_inst.rd(a, dr, ok);
		chk_lvl(ok, 1'b1, "read answer");
		chk8(dr, exp_rd(a), "read data");
	endtask

	task automatic pulses(input int ei, input int eb, input int es, input int ec);
		repeat (48) @(negedge mclk);
		chk_cnt(lo[0] - base[0], ei, "init low");
		chk_cnt(lo[1] - base[1], eb, "bus reset low");
		for (int k = 2; k < 5; k++)
			chk_cnt(lo[k] - base[k], es, "sleep low");
		chk_cnt(lo[5] - base[5], ec, "resume clear");
		base = lo;
	endtask

	task automatic pin_set();
		psc_host_model_inst.set_pins(p);
		repeat (8) @(negedge mclk);
	endtask

	// ============================================================
	// test sequence
	initial begin
		p = 5'h0e;
		void'($urandom(54518));
		repeat (16) @(negedge mclk);
		rst_n = 1'b1;
		repeat (8) @(negedge mclk);
		base = lo;
		chk_lvl(a20_n, 1'b0, "addr20 at reset");
		foreach (ADDRS[i])
			io_read(ADDRS[i]);
		$display("reset values done");
		for (int i = 0; i < 6; i++) begin
			d = 8'($urandom);
			alt = 1'($urandom);
			io_write(i[0] ? 16'h0074 : 16'h0070, d);
			@(negedge mclk);
			chk_lvl(nmi, d[7], "nmi mask");
			chk8({1'b0, sel}, {1'b0, d[6:0]}, "clock select");
			io_read(16'h0070);
			io_read(16'h0074);
		end
		$display("nmi and index done");
		base = lo;
		io_write(16'h0092, 8'h01);
		pulses(16, 0, 0, 0);
		io_read(16'h0092);
		chk_lvl(a20_n, 1'b1, "addr20 after init");
		io_write(16'h0092, 8'h03);
		pulses(0, 0, 0, 0);
		io_write(16'h0092, 8'h00);
		@(negedge mclk);
		chk_lvl(a20_n, 1'b0, "addr20 open");
		p.addr20_gate = 1'b1;
		pin_set();
		chk_lvl(a20_n, 1'b1, "addr20 gated");
		p.addr20_gate = 1'b0;
		pin_set();
		base = lo;
		$display("fast gate done");
		io_write(16'h0cf9, 8'h04);
		pulses(16, 0, 0, 0);
		io_read(16'h0092);
		io_write(16'h0cf9, 8'h04);
		pulses(0, 0, 0, 0);
		io_write(16'h0cf9, 8'h00);
		io_write(16'h0cf9, 8'h06);
		pulses(0, 20, 0, 1);
		io_write(16'h0cf9, 8'h08);
		io_write(16'h0cf9, 8'h0e);
		pulses(0, 20, 30, 1);
		io_read(16'h0cf9);
		$display("reset control done");
		p.power_good = 1'b0;
		pin_set();
		pulses(0, 0, 30, 0);
		p.power_good = 1'b1;
		pin_set();
		for (int i = 0; i < 2; i++) begin
			p.wdt_timeout = 1'b1;
			pin_set();
			p.wdt_timeout = 1'b0;
			pin_set();
		end
		pulses(0, 0, 30, 0);
		$display("power events done");
		p.float_err_n = 1'b0;
		pin_set();
		chk_lvl(fpu, 1'b0, "irq while disabled");
		io_write(16'h00f0, 8'($urandom));
		@(negedge mclk);
		chk_lvl(ign_n, 1'b1, "ignore_numeric_error_out without irq");
		irq_en = 1'b1;
		repeat (4) @(negedge mclk);
		chk_lvl(fpu, 1'b1, "irq enabled");
		io_write(16'h00f0, 8'($urandom));
		@(negedge mclk);
		chk_lvl(ign_n, 1'b0, "ignore_numeric_error_out after ack");
		io_read(16'h00f0);
		p.float_err_n = 1'b1;
		pin_set();
		chk_lvl(ign_n, 1'b1, "ignore_numeric_error_out released");
		chk_lvl(fpu, 1'b0, "irq cleared");
		$display("numeric error done");
		results();
	end
endmodule

`default_nettype wire
